//--- core/txdcc_core.v
// Transmit driver and transmit CRC configuration bank on Avalon-MM
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "txdcc_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module txdcc_core (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        internal_envelope,
  input  wire        external_signal_input,
  input  wire        driverA,
  input  wire        driverB,
  input  wire [15:0] nvmCrcStart,
  output reg         antennaPinAOut,
  output reg         antennaPinAOe_n,
  output reg         antennaPinBOut,
  output reg         antennaPinBOe_n,
  output reg  [2:0]  driverOutputMode,
  output reg  [1:0]  carrierLevelReduce,
  output reg         carrierMax,
  output reg  [4:0]  residualCarrier,
  output reg         modulationOut,
  output reg  [3:0]  overshootLenA,
  output reg  [3:0]  overshootLenB,
  output reg  [3:0]  loadCurrentTrim,
  output reg  [1:0]  crcWidth,
  output reg  [15:0] crcStartValue,
  output reg         crcComplement,
  output reg         crcAppendEnable,
  output reg         crcConfigBad
);

  localparam [1:0] ST_IDLE = `TXDCC_CYC_IDLE;
  localparam [1:0] ST_WAIT = `TXDCC_CYC_WAIT;

  reg  [7:0]  driver_mode_q;
  reg  [7:0]  carrAmp_q;
  reg  [7:0]  txCtrl_q;
  reg  [7:0]  ovsLoad_q;
  reg  [7:0]  crcSetup_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [31:0] rdData_d;
  reg  [15:0] start_d;
  reg         bad_d;
  reg         modSel_d;
  reg         pinA_d;
  reg         pinB_d;
  reg         oeA_n_d;
  reg         oeB_n_d;
  wire        wrLane;
  wire        busReq;
  wire [2:0]  selCode;
  wire [2:0]  modeCode;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, the access completes in the second cycle
  assign busReq = avs_read | avs_write;
  assign wrLane = avs_write & avs_byteenable[0] & (state_q == ST_WAIT);

  always @* begin
    case (state_q)
      ST_IDLE: state_d = busReq ? ST_WAIT : ST_IDLE;
      ST_WAIT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q         <= ST_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      state_q         <= state_d;
      // Waitrequest drops exactly in the cycle the access completes
      avs_waitrequest <= ~(state_d == ST_WAIT);
    end
  end

  // Reserved bits are masked on write so they always read zero
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      driver_mode_q  <= `TXDCC_DRV_MODE_RST;
      carrAmp_q  <= `TXDCC_CARR_AMP_RST;
      txCtrl_q   <= `TXDCC_TX_CTRL_RST;
      ovsLoad_q  <= `TXDCC_OVS_LOAD_RST;
      crcSetup_q <= `TXDCC_CRC_SETUP_RST;
    end else if (wrLane) begin
      case (avs_address)
        `TXDCC_OFS_DRV_MODE:
          driver_mode_q <= avs_writedata[7:0] & `TXDCC_DRV_MODE_MASK;
        `TXDCC_OFS_CARR_AMP:
          carrAmp_q <= avs_writedata[7:0] & `TXDCC_CARR_AMP_MASK;
        `TXDCC_OFS_TX_CTRL:
          txCtrl_q <= avs_writedata[7:0];
        `TXDCC_OFS_OVS_LOAD:
          ovsLoad_q <= avs_writedata[7:0];
        `TXDCC_OFS_CRC_SETUP:
          crcSetup_q <= avs_writedata[7:0] & `TXDCC_CRC_SETUP_MASK;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read zero and swallow writes
  always @* begin
    rdData_d = 32'h0000_0000;
    case (avs_address)
      `TXDCC_OFS_DRV_MODE:  rdData_d[7:0] = driver_mode_q;
      `TXDCC_OFS_CARR_AMP:  rdData_d[7:0] = carrAmp_q;
      `TXDCC_OFS_TX_CTRL:   rdData_d[7:0] = txCtrl_q;
      `TXDCC_OFS_OVS_LOAD:  rdData_d[7:0] = ovsLoad_q;
      `TXDCC_OFS_CRC_SETUP: rdData_d[7:0] = crcSetup_q;
      `TXDCC_OFS_STATUS:    rdData_d[0]   = crcConfigBad;
      default:              rdData_d      = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && state_d == ST_WAIT)
      avs_readdata <= rdData_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC start value lookup
  assign selCode = crcSetup_q[`TXDCC_FLD_START_SEL];

  always @* begin
    start_d = 16'h0000;
    bad_d   = 1'b0;
    case (crcSetup_q[`TXDCC_FLD_CRC_WIDTH])
      `TXDCC_CRC_W16: begin
        case (selCode)
          3'h0: start_d = `TXDCC_P16_0;
          3'h1: start_d = `TXDCC_P16_1;
          3'h2: start_d = `TXDCC_P16_2;
          3'h3: start_d = `TXDCC_P16_3;
          3'h6: start_d = nvmCrcStart;
          3'h7: start_d = `TXDCC_P16_7;
          default: bad_d = 1'b1;
        endcase
      end
      `TXDCC_CRC_W8: begin
        case (selCode)
          3'h0: start_d[7:0] = `TXDCC_P8_0;
          3'h1: start_d[7:0] = `TXDCC_P8_1;
          3'h2: start_d[7:0] = `TXDCC_P8_2;
          3'h3: start_d[7:0] = `TXDCC_P8_3;
          3'h6: start_d[7:0] = nvmCrcStart[7:0];
          3'h7: start_d[7:0] = `TXDCC_P8_7;
          default: bad_d = 1'b1;
        endcase
      end
      `TXDCC_CRC_W5: begin
        case (selCode)
          3'h0: start_d[4:0] = `TXDCC_P5_0;
          3'h1: start_d[4:0] = `TXDCC_P5_1;
          3'h6: start_d[4:0] = nvmCrcStart[4:0];
          3'h7: start_d[4:0] = `TXDCC_P5_7;
          default: bad_d = 1'b1;
        endcase
      end
      default: bad_d = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulation source and antenna pins
  always @* begin
    case (txCtrl_q[`TXDCC_FLD_MOD_SEL])
      `TXDCC_SEL_ENVELOPE: modSel_d = internal_envelope;
      `TXDCC_SEL_EXTERNAL: modSel_d = external_signal_input;
      default:             modSel_d = 1'b0;
    endcase
  end

  assign modeCode = driver_mode_q[`TXDCC_FLD_OUT_MODE];

  // Modes: 0 push-pull, 1 drain (low drives, high floats), 2 high impedance,
  // 4 fixed low, 5 fixed high, 7 push-pull; 3 and 6 are not supported
  // and are treated as high impedance so a bad code never fights the antenna
  always @* begin
    pinA_d  = driverA ^ driver_mode_q[`TXDCC_BIT_DRV_A_INV];
    pinB_d  = driverB ^ driver_mode_q[`TXDCC_BIT_DRV_B_INV];
    oeA_n_d = 1'b0;
    oeB_n_d = 1'b0;
    case (modeCode)
      3'h0, 3'h7: ;
      3'h1: begin
        oeA_n_d = pinA_d;
        oeB_n_d = pinB_d;
      end
      3'h4: begin
        pinA_d = 1'b0;
        pinB_d = 1'b0;
      end
      3'h5: begin
        pinA_d = 1'b1;
        pinB_d = 1'b1;
      end
      default: begin
        oeA_n_d = 1'b1;
        oeB_n_d = 1'b1;
      end
    endcase
    if (!driver_mode_q[`TXDCC_BIT_DRV_EN]) begin
      oeA_n_d = 1'b1;
      oeB_n_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward drivers and framer
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      antennaPinAOut     <= 1'b0;
      antennaPinAOe_n    <= 1'b1;
      antennaPinBOut     <= 1'b0;
      antennaPinBOe_n    <= 1'b1;
      driverOutputMode   <= 3'h0;
      carrierLevelReduce <= 2'h0;
      carrierMax         <= 1'b0;
      residualCarrier    <= 5'h00;
      modulationOut      <= 1'b0;
      overshootLenA      <= 4'h0;
      overshootLenB      <= 4'h0;
      loadCurrentTrim    <= 4'h0;
      crcWidth           <= 2'h0;
      crcStartValue      <= 16'h0000;
      crcComplement      <= 1'b0;
      crcAppendEnable    <= 1'b0;
      crcConfigBad       <= 1'b0;
    end else begin
      antennaPinAOut     <= pinA_d;
      antennaPinAOe_n    <= oeA_n_d;
      antennaPinBOut     <= pinB_d;
      antennaPinBOe_n    <= oeB_n_d;
      driverOutputMode   <= modeCode;
      // Max carrier forces zero reduction so the analog side sees one knob
      carrierLevelReduce <= txCtrl_q[`TXDCC_BIT_CW_MAX] ? 2'h0 :
                            carrAmp_q[`TXDCC_FLD_LVL_REDUCE];
      carrierMax         <= txCtrl_q[`TXDCC_BIT_CW_MAX];
      residualCarrier    <= carrAmp_q[`TXDCC_FLD_RESIDUAL];
      modulationOut      <= modSel_d ^ txCtrl_q[`TXDCC_BIT_MOD_INV];
      overshootLenB      <= txCtrl_q[`TXDCC_FLD_OVS_B];
      overshootLenA      <= ovsLoad_q[`TXDCC_FLD_OVS_A];
      loadCurrentTrim    <= ovsLoad_q[`TXDCC_FLD_LOAD_TRIM];
      crcWidth           <= crcSetup_q[`TXDCC_FLD_CRC_WIDTH];
      crcStartValue      <= start_d;
      crcComplement      <= crcSetup_q[`TXDCC_BIT_CRC_COMPL];
      crcAppendEnable    <= crcSetup_q[`TXDCC_BIT_CRC_APPEND];
      crcConfigBad       <= bad_d;
    end
  end

endmodule
`default_nettype wire

//--- inc/txdcc_regs.vh
// Register offsets, field positions, reset values and CRC start tables
`ifndef TXDCC_REGS_VH
`define TXDCC_REGS_VH

`define TXDCC_ADDR_W          6
`define TXDCC_OFS_DRV_MODE    6'h28
`define TXDCC_OFS_CARR_AMP    6'h29
`define TXDCC_OFS_TX_CTRL     6'h2A
`define TXDCC_OFS_OVS_LOAD    6'h2B
`define TXDCC_OFS_CRC_SETUP   6'h2C
`define TXDCC_OFS_STATUS      6'h2F

`define TXDCC_DRV_MODE_RST    8'h00
`define TXDCC_CARR_AMP_RST    8'h00
`define TXDCC_TX_CTRL_RST     8'h00
`define TXDCC_OVS_LOAD_RST    8'h00
`define TXDCC_CRC_SETUP_RST   8'h00

`define TXDCC_DRV_MODE_MASK   8'hCF
`define TXDCC_CARR_AMP_MASK   8'hDF
`define TXDCC_CRC_SETUP_MASK  8'h7F

`define TXDCC_BIT_DRV_B_INV   7
`define TXDCC_BIT_DRV_A_INV   6
`define TXDCC_BIT_DRV_EN      3
`define TXDCC_FLD_OUT_MODE    2:0
`define TXDCC_FLD_LVL_REDUCE  7:6
`define TXDCC_FLD_RESIDUAL    4:0
`define TXDCC_FLD_OVS_B       7:4
`define TXDCC_BIT_CW_MAX      3
`define TXDCC_BIT_MOD_INV     2
`define TXDCC_FLD_MOD_SEL     1:0
`define TXDCC_FLD_OVS_A       7:4
`define TXDCC_FLD_LOAD_TRIM   3:0
`define TXDCC_FLD_START_SEL   6:4
`define TXDCC_FLD_CRC_WIDTH   3:2
`define TXDCC_BIT_CRC_COMPL   1
`define TXDCC_BIT_CRC_APPEND  0

`define TXDCC_MODE_OD_BAD1    3'h3
`define TXDCC_MODE_OD_BAD2    3'h6
`define TXDCC_SEL_NONE        2'h0
`define TXDCC_SEL_ENVELOPE    2'h1
`define TXDCC_SEL_EXTERNAL    2'h2
`define TXDCC_CRC_W5          2'h0
`define TXDCC_CRC_W8          2'h1
`define TXDCC_CRC_W16         2'h2

`define TXDCC_P16_0           16'h0000
`define TXDCC_P16_1           16'h6363
`define TXDCC_P16_2           16'hA671
`define TXDCC_P16_3           16'hFFFE
`define TXDCC_P16_7           16'hFFFF
`define TXDCC_P8_0            8'h00
`define TXDCC_P8_1            8'h12
`define TXDCC_P8_2            8'hBF
`define TXDCC_P8_3            8'hFD
`define TXDCC_P8_7            8'hFF
`define TXDCC_P5_0            5'h00
`define TXDCC_P5_1            5'h12
`define TXDCC_P5_7            5'h1F

`define TXDCC_CYC_IDLE        2'h1
`define TXDCC_CYC_WAIT        2'h2

`endif

//--- test/txdcc_antenna_model.sv
// Antenna pin model: each pin wire with a pull-up through the coil
`timescale 1ns/10ps
`default_nettype none
module txdcc_antenna_model (
  input  wire logic antennaPinAOut,
  input  wire logic antennaPinAOe_n,
  input  wire logic antennaPinBOut,
  input  wire logic antennaPinBOe_n,
  output logic      levelA,
  output logic      levelB
);
  // A released pin rises to the pull-up level, never holds its last value
  assign levelA = antennaPinAOe_n ? 1'b1 : antennaPinAOut;
  assign levelB = antennaPinBOe_n ? 1'b1 : antennaPinBOut;
endmodule
`default_nettype wire

//--- test/txdcc_core_test.sv
// Self-checking bench for the transmit configuration bank
`timescale 1ns/10ps
`default_nettype none
module txdcc_core_test;
  logic ref_clk = 1'b0, reset_n, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, lfsr = 32'h9AF72B83;
  logic [3:0] avs_byteenable = 4'hF;
  logic internal_envelope = 1'b0, external_signal_input = 1'b0;
  logic driverA = 1'b0, driverB = 1'b0, avs_waitrequest, levelA, levelB;
  logic [15:0] nvmCrcStart = 16'h0000, crcStartValue;
  logic antennaPinAOut, antennaPinAOe_n, antennaPinBOut, antennaPinBOe_n;
  logic carrierMax, modulationOut, crcComplement, crcAppendEnable;
  logic crcConfigBad;
  logic [2:0] driverOutputMode;
  logic [1:0] carrierLevelReduce, crcWidth;
  logic [4:0] residualCarrier;
  logic [3:0] overshootLenA, overshootLenB, loadCurrentTrim;
  logic [7:0] a, b, c, d;
  logic [16:0] e;
  logic [31:0] expQ[$];
  logic [7:0] mask [5] = '{8'hCF, 8'hDF, 8'hFF, 8'hFF, 8'h7F};
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
  int err_count = 0, comparisons = 0, i, w;
  txdcc_core uut (.*);
  txdcc_antenna_model partner (.*);
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic pinLvl(input logic [7:0] m, input logic v);
    if (!m[3] || m[2:0] == 3'h5 || m[2:0] == 3'h2)
      return 1'b1;
    return (m[2:0] == 3'h4) ? 1'b0 : v;
  endfunction
  function automatic logic [16:0] crcExp(input logic [1:0] cw, input logic [2:0] k);
    logic [15:0] t16 [8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFE, 16'h0, 16'h0, 16'h0, 16'hFFFF};
    logic [7:0] t8 [8] = '{8'h00, 8'h12, 8'hBF, 8'hFD, 8'h0, 8'h0, 8'h0, 8'hFF};
    logic [15:0] v;
    if (cw == 2'h3 || k == 3'h4 || k == 3'h5 || (cw == 2'h0 && (k == 3'h2 || k == 3'h3)))
      return {1'b1, 16'h0};
    v = (k == 3'h6) ? nvmCrcStart : (k == 3'h7 && cw == 2'h0) ? 16'h001F : (cw == 2'h2) ? t16[k] : {8'h00, t8[k]};
    return {1'b0, (cw == 2'h2) ? v : (cw == 2'h1) ? {8'h00, v[7:0]} : {11'h0, v[4:0]}};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Errors %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic access(input logic rd, input logic [5:0] ad, input logic [7:0] dt);
    int n;
    logic [31:0] r;
    n = 0;
    @(posedge ref_clk);
    r = rnd();
    avs_address <= ad;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {r[31:8], dt};
    {internal_envelope, external_signal_input, driverA, driverB} <= r[3:0];
    nvmCrcStart <= r[23:8];
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      give_verdict();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ad, input logic [7:0] ex);
    expQ.push_back({24'h0, ex});
    access(1'b1, ad, 8'h00);
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
    access(1'b0, ad, dt);
    repeat (2) @(negedge ref_clk);
  endtask
  always @(posedge ref_clk)
    if (reset_n && avs_read && avs_waitrequest === 1'b0)
      check(avs_readdata, expQ.size() ? expQ.pop_front() : 32'hFFFFFFFF);
  ////////////////////////////////////////
  initial begin
    // Reset held low across five clock edges so the asynchronous reset branch surely runs
    reset_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    check({antennaPinAOe_n, antennaPinBOe_n}, 32'h3);
    reset_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(6'h28 + i[5:0], 8'h00);
      wr(6'h28 + i[5:0], 8'hFF);
      rd(6'h28 + i[5:0], mask[i]);
    end
    rd(6'h2F, 8'h01);
    wr(6'h10, 8'hFF);
    rd(6'h10, 8'h00);
    avs_byteenable <= 4'hE;
    wr(6'h2A, 8'h00);
    avs_byteenable <= 4'hF;
    rd(6'h2A, 8'hFF);
    for (i = 0; i < 12; i++) begin
      {d, a, b, c} = rnd();
      b[1:0] = i % 3;
      wr(6'h29, a);
      wr(6'h2A, b);
      wr(6'h2B, c);
      check(carrierLevelReduce, b[3] ? 2'h0 : a[7:6]);
      check(residualCarrier, a[4:0]);
      check({carrierMax, overshootLenB}, {b[3], b[7:4]});
      check({overshootLenA, loadCurrentTrim}, c);
      check(modulationOut, b[2] ^ (b[1:0] == 2'h1 ? internal_envelope : b[0] ? 1'b0 : b[1] & external_signal_input));
      d = rnd();
      d[3:0] = {i % 4 != 0, modes[i % 6]};
      wr(6'h28, d);
      check({levelA, levelB}, {pinLvl(d, driverA ^ d[6]), pinLvl(d, driverB ^ d[7])});
      check(driverOutputMode, d[2:0]);
      if (!d[3] || d[2:0] == 3'h0 || d[2:0] == 3'h7)
        check({antennaPinAOe_n, antennaPinBOe_n}, {2{!d[3]}});
    end
    for (w = 0; w < 32; w++) begin
      void'(rnd());
      d = {1'b0, w[2:0], w[4:3], lfsr[1:0]};
      wr(6'h2C, d);
      e = crcExp(d[3:2], d[6:4]);
      check({crcWidth, crcComplement, crcAppendEnable}, d[3:0]);
      check(crcConfigBad, e[16]);
      if (!e[16])
        check(crcStartValue, e[15:0]);
    end
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- test/txdcc_props.sv
// Port assertions for the transmit configuration bank
`timescale 1ns/10ps
`default_nettype none
module txdcc_props (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        carrierMax,
  input wire logic [1:0]  carrierLevelReduce,
  input wire logic [4:0]  residualCarrier,
  input wire logic [3:0]  loadCurrentTrim,
  input wire logic [1:0]  crcWidth,
  input wire logic [15:0] crcStartValue,
  input wire logic        crcConfigBad
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Outputs follow a completed write two edges later
  wire wrDone = !avs_waitrequest && avs_write && avs_byteenable[0];
  a_wait_answer: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("access not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_rd_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest && avs_read)
    else $error("read data moved outside a read");
  a_rd_upper: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_cw_override: assert property (carrierMax |-> carrierLevelReduce == 2'h0)
    else $error("level reduce active at max carrier");
  a_crc_bad: assert property (crcWidth == 2'h3 |-> crcConfigBad)
    else $error("reserved CRC width not flagged");
  a_crc_narrow: assert property (crcWidth == 2'h0 |-> crcStartValue[15:5] == 11'h000)
    else $error("CRC5 start value too wide");
  a_residual_wr: assert property (wrDone && avs_address == 6'h29 |=> ##1 residualCarrier == $past(avs_writedata[4:0], 2))
    else $error("residual carrier not updated");
  a_trim_wr: assert property (wrDone && avs_address == 6'h2B |=> ##1 loadCurrentTrim == $past(avs_writedata[3:0], 2))
    else $error("load trim not updated");
  a_max_wr: assert property (wrDone && avs_address == 6'h2A |=> ##1 carrierMax == $past(avs_writedata[3], 2))
    else $error("max carrier not updated");
endmodule
bind txdcc_core txdcc_props u_props (.*);
`default_nettype wire
